// [design/cecrx_pkg.sv]
package cecrx_pkg;
   // Clock and bit-timing base; one tick is one step of the line timing.
   // TICK_NS / CLK_NS clocks a tick keep true line time; one clock a tick
   // runs the line that much faster, which keeps test runs short.
   localparam int CLK_NS = 50;
   localparam int TICK_NS = 10000;
   localparam int TICK_CYC = 1;
   localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
   // Line timing in microseconds and in ticks.
   localparam int START_MIN_US = 3500;
   localparam int START_MAX_US = 3900;
   localparam int SAMPLE_US = 1050;
   localparam int ACK_LOW_US = 1500;
   localparam int TIMEOUT_US = 4700;
   localparam logic [8:0] START_MIN_TK =
      9'((START_MIN_US * 1000 + TICK_NS - 1) / TICK_NS);
   localparam logic [8:0] START_MAX_TK = 9'(START_MAX_US * 1000 / TICK_NS);
   localparam logic [8:0] SAMPLE_TK = 9'(SAMPLE_US * 1000 / TICK_NS);
   localparam logic [8:0] ACK_LOW_TK =
      9'((ACK_LOW_US * 1000 + TICK_NS - 1) / TICK_NS);
   localparam logic [8:0] TIMEOUT_TK = 9'(TIMEOUT_US * 1000 / TICK_NS);
   localparam logic [8:0] TCNT_MAX = 9'h1FF;
   // Register indices; byte address is four times the index.
   localparam logic [7:0] IDX_TX_START = 8'h11;
   localparam logic [7:0] IDX_TX_ERR = 8'h14;
   localparam logic [7:0] IDX_BUF0 = 8'h15;
   localparam logic [7:0] IDX_LEN0 = 8'h25;
   localparam logic [7:0] IDX_CTRL = 8'h27;
   localparam logic [7:0] IDX_ADDR_PAIR = 8'h28;
   localparam logic [7:0] IDX_ADDR_THIRD = 8'h29;
   localparam logic [7:0] IDX_POWER = 8'h2A;
   localparam logic [7:0] IDX_CLEAR = 8'h2C;
   localparam logic [7:0] IDX_STAMPS = 8'h53;
   localparam logic [7:0] IDX_BUF1 = 8'h54;
   localparam logic [7:0] IDX_LEN1 = 8'h64;
   localparam logic [7:0] IDX_BUF2 = 8'h65;
   localparam logic [7:0] IDX_LEN2 = 8'h75;
   localparam logic [7:0] IDX_BUFSEL = 8'h77;
   localparam logic [7:0] IDX_STATUS = 8'h93;
   localparam logic [7:0] IDX_MASK_A = 8'h94;
   localparam logic [7:0] IDX_MASK_B = 8'h95;
   // Field positions.
   localparam int TX_START_BIT = 0;
   localparam int SUPPRESS_BIT = 1;
   localparam int EN_LSB = 4;
   localparam int EN_MSB = 6;
   localparam int CLR_LSB = 1;
   localparam int CLR_MSB = 3;
   localparam int RDY_LSB = 3;
   localparam int RDY_MSB = 5;
   // Reset values.
   localparam logic [7:0] ADDR_PAIR_RST = 8'hFF;
   localparam logic [3:0] ADDR_THIRD_RST = 4'hF;
   // Frame layout.
   localparam logic [4:0] FRAME_BYTES = 5'h10;
   localparam logic [4:0] MIN_STORE_LEN = 5'h02;
   localparam logic [3:0] EOM_BIT = 4'h8;
   localparam logic [3:0] ACK_BIT = 4'h9;
   localparam logic [3:0] LD_MAX = 4'hF;
   localparam logic [1:0] TS_EMPTY = 2'h0;
   localparam logic LINE_IDLE = 1'b1;

   typedef struct packed {
      logic read;
      logic write;
      logic [9:0] address;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } cecrx_req_t;

   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_START = 2'b01,
      RX_WAIT = 2'b11,
      RX_BIT = 2'b10
   } cecrx_state_t;
endpackage : cecrx_pkg

// [design/cecrx_follower.sv]
// What this block does
// - Four-bit low-drive error count, cleared when the host starts sending.
// - Once powered on, the receiver watches the bus for addressed frames.
// - A completed frame raises an interrupt when its mask allows it.
// - A control bit withholds acknowledge of all frames; reset leaves it clear.
// - Up to three logical addresses may be active together.
// - Each address matches only while its own enable bit is set.
// - Enable bits 4, 5, 6 gate addresses 0, 1, 2; any match accepts.
// - Three buffers hold three frames; later frames are not stored until a host clear write.
// - In single-buffer mode one held frame blocks further reception.
// - Buffer select bit: 0 uses buffer 0 only, 1 uses all three.
// - Each buffer has a two-bit arrival order and a ready flag.
// - Order 00 means empty; 01, 10, 11 give first, second, third.
// - Buffer 0 ready status sets on arrival and holds until cleared.
// - Buffer 1 ready status sets on arrival and holds until cleared.
// - Latched status counts only while an interrupt mask enables it.
// - A non-polling frame goes to the lowest free buffer and is ordered.
// - With no free buffer, only the header of a frame is acknowledged.
// - Each buffer reports its frame length, header byte included.
`timescale 1ns/1ps
`default_nettype none
module cecrx_follower
   import cecrx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire cecrx_req_t av_req,
   output logic [31:0] av_readdata,
   output logic av_waitrequest,
   input wire logic cec_in,
   output logic cec_out,
   output logic cec_oe_b,
   input wire logic tx_low_drive_error,
   output logic tx_start_pulse,
   output logic interrupt_out_a,
   output logic interrupt_out_b
);

   function automatic logic in_win(input logic [7:0] i, input logic [7:0] b);
      return (i >= b) && (i < b + 8'(FRAME_BYTES));
   endfunction : in_win

   function automatic logic [1:0] count3(input logic [2:0] v);
      return 2'(v[0]) + 2'(v[1]) + 2'(v[2]);
   endfunction : count3

   logic wait_q, wr_go;
   logic [7:0] idx, wd, rval;
   logic [31:0] rdata_q;
   logic [7:0] ctrl_q, addr_pair_q;
   logic [3:0] addr3_q, ld_cnt_q;
   logic power_q, triple_q, start_q, int_a_q, int_b_q;
   logic [2:0] mask_a_q, mask_b_q, full_q, full_d, rel, vis;
   logic [2:0][1:0] ts_q, ts_d;
   logic [2:0][4:0] len_q;
   logic [7:0] mem_q [0:2][0:15];
   cecrx_state_t st_q;
   logic [7:0] tick_q, shift_q;
   logic tk_q, line_q, prev_q, fall, rise, sample_now;
   logic [8:0] tcnt_q;
   logic [3:0] bitcnt_q;
   logic [4:0] nbytes_q;
   logic hit_q, slot_ok_q, eom_q, ack_ok_q, oe_b_q, commit_q;
   logic [1:0] slot_q, free_slot, wslot, rs;
   logic free_ok, dest_hit, head_ok, mem_we;
   logic w0, w1, w2;
   logic [7:0] rbase;
   logic [3:0] roff;
   logic [2:0] en;

   // Bus decode.
   assign idx = av_req.address[9:2];
   assign wd = av_req.writedata[7:0];
   assign wr_go = av_req.write & ~wait_q & av_req.byteenable[0];
   assign en = ctrl_q[EN_MSB:EN_LSB];
   assign vis = mask_a_q | mask_b_q;
   assign rel = (wr_go && idx == IDX_CLEAR) ?
      (wd[CLR_MSB:CLR_LSB] & full_q) : 3'h0;

   // Read selection.
   assign w0 = in_win(idx, IDX_BUF0);
   assign w1 = in_win(idx, IDX_BUF1);
   assign w2 = in_win(idx, IDX_BUF2);
   assign rbase = w1 ? IDX_BUF1 : (w2 ? IDX_BUF2 : IDX_BUF0);
   assign rs = w1 ? 2'h1 : (w2 ? 2'h2 : 2'h0);
   assign roff = 4'(idx - rbase);
   assign rval =
      (w0 | w1 | w2) ? mem_q[rs][roff] :
      (idx == IDX_TX_ERR) ? {ld_cnt_q, 4'h0} :
      (idx == IDX_LEN0) ? {3'h0, len_q[0]} :
      (idx == IDX_LEN1) ? {3'h0, len_q[1]} :
      (idx == IDX_LEN2) ? {3'h0, len_q[2]} :
      (idx == IDX_CTRL) ? ctrl_q :
      (idx == IDX_ADDR_PAIR) ? addr_pair_q :
      (idx == IDX_ADDR_THIRD) ? {4'h0, addr3_q} :
      (idx == IDX_POWER) ? {7'h00, power_q} :
      (idx == IDX_STAMPS) ? {2'h0, ts_q[2], ts_q[1], ts_q[0]} :
      (idx == IDX_BUFSEL) ? {7'h00, triple_q} :
      (idx == IDX_STATUS) ? {2'h0, full_q & vis, 3'h0} :
      (idx == IDX_MASK_A) ? {2'h0, mask_a_q, 3'h0} :
      (idx == IDX_MASK_B) ? {2'h0, mask_b_q, 3'h0} : 8'h00;

   // Bus handshake: waitrequest drops one cycle after a request appears.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end else begin
         wait_q <= ~((av_req.read | av_req.write) & wait_q);
         if (av_req.read & wait_q) begin
            rdata_q <= {24'h000000, rval};
         end
      end
   end

   // Host-written configuration.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= 8'h00;
         addr_pair_q <= ADDR_PAIR_RST;
         addr3_q <= ADDR_THIRD_RST;
         power_q <= 1'b0;
         triple_q <= 1'b0;
         mask_a_q <= 3'h0;
         mask_b_q <= 3'h0;
      end else if (wr_go) begin
         if (idx == IDX_CTRL) begin
            ctrl_q <= {1'b0, wd[EN_MSB:EN_LSB], 2'h0, wd[SUPPRESS_BIT], 1'b0};
         end else if (idx == IDX_ADDR_PAIR) begin
            addr_pair_q <= wd;
         end else if (idx == IDX_ADDR_THIRD) begin
            addr3_q <= wd[3:0];
         end else if (idx == IDX_POWER) begin
            power_q <= wd[0];
         end else if (idx == IDX_BUFSEL) begin
            triple_q <= wd[0];
         end else if (idx == IDX_MASK_A) begin
            mask_a_q <= wd[RDY_MSB:RDY_LSB];
         end else if (idx == IDX_MASK_B) begin
            mask_b_q <= wd[RDY_MSB:RDY_LSB];
         end
      end
   end

   // Low-drive error count and transmit start pulse.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ld_cnt_q <= 4'h0;
         start_q <= 1'b0;
      end else begin
         start_q <= wr_go && idx == IDX_TX_START && wd[TX_START_BIT];
         if (wr_go && idx == IDX_TX_START && wd[TX_START_BIT]) begin
            ld_cnt_q <= 4'h0;
         end else if (tx_low_drive_error && ld_cnt_q != LD_MAX) begin
            ld_cnt_q <= ld_cnt_q + 4'h1;
         end
      end
   end

   // Buffer occupancy and arrival order.
   always_comb begin
      full_d = full_q & ~rel;
      ts_d = ts_q;
      for (int i = 0; i < 3; i++) begin
         if (rel[i]) begin
            ts_d[i] = TS_EMPTY;
         end else begin
            for (int j = 0; j < 3; j++) begin
               if (rel[j] && full_q[i] && ts_q[j] < ts_q[i]) begin
                  ts_d[i] = ts_d[i] - 2'h1;
               end
            end
         end
      end
      if (commit_q) begin
         ts_d[slot_q] = count3(full_d) + 2'h1;
         full_d[slot_q] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         full_q <= 3'h0;
         ts_q <= '0;
         len_q <= '0;
         int_a_q <= 1'b0;
         int_b_q <= 1'b0;
      end else begin
         full_q <= full_d;
         ts_q <= ts_d;
         if (commit_q) begin
            len_q[slot_q] <= nbytes_q;
         end
         int_a_q <= |(full_q & mask_a_q);
         int_b_q <= |(full_q & mask_b_q);
      end
   end

   // Slot choice and address match.
   assign free_ok = triple_q ? ~&full_q : ~full_q[0];
   assign free_slot = ~full_q[0] ? 2'h0 : (~full_q[1] ? 2'h1 : 2'h2);
   assign dest_hit = (en[0] && shift_q[3:0] == addr_pair_q[3:0]) |
      (en[1] && shift_q[3:0] == addr_pair_q[7:4]) |
      (en[2] && shift_q[3:0] == addr3_q);
   assign head_ok = dest_hit & ~ctrl_q[SUPPRESS_BIT];
   assign wslot = (nbytes_q == 5'h00) ? free_slot : slot_q;

   // Line sampling and timing ticks.
   assign fall = prev_q & ~line_q;
   assign rise = ~prev_q & line_q;
   assign sample_now = (st_q == RX_BIT) && tk_q && tcnt_q == SAMPLE_TK;
   assign mem_we = sample_now && bitcnt_q == EOM_BIT &&
      nbytes_q < FRAME_BYTES &&
      ((nbytes_q == 5'h00) ? (head_ok & free_ok) : (hit_q & slot_ok_q));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tick_q <= 8'h00;
         tk_q <= 1'b0;
         line_q <= LINE_IDLE;
         prev_q <= LINE_IDLE;
         tcnt_q <= 9'h000;
      end else begin
         tk_q <= tick_q == TICK_LAST;
         tick_q <= (tick_q == TICK_LAST) ? 8'h00 : tick_q + 8'h01;
         line_q <= cec_in;
         prev_q <= line_q;
         if (fall) begin
            tcnt_q <= 9'h000;
         end else if (tk_q && tcnt_q != TCNT_MAX) begin
            tcnt_q <= tcnt_q + 9'h001;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (mem_we) begin
         mem_q[wslot][nbytes_q[3:0]] <= shift_q;
      end
   end

   // Receive sequencer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= RX_IDLE;
         shift_q <= 8'h00;
         bitcnt_q <= 4'h0;
         nbytes_q <= 5'h00;
         hit_q <= 1'b0;
         slot_q <= 2'h0;
         slot_ok_q <= 1'b0;
         eom_q <= 1'b0;
         ack_ok_q <= 1'b0;
         oe_b_q <= 1'b1;
         commit_q <= 1'b0;
      end else begin
         commit_q <= 1'b0;
         if (tk_q && tcnt_q == ACK_LOW_TK) begin
            oe_b_q <= 1'b1;
         end
         case (st_q)
            RX_IDLE: begin
               if (fall && power_q) begin
                  st_q <= RX_START;
               end
            end
            RX_START: begin
               if (rise) begin
                  if (tcnt_q >= START_MIN_TK && tcnt_q <= START_MAX_TK) begin
                     st_q <= RX_WAIT;
                     bitcnt_q <= 4'h0;
                     nbytes_q <= 5'h00;
                     hit_q <= 1'b0;
                     slot_ok_q <= 1'b0;
                  end else begin
                     st_q <= RX_IDLE;
                  end
               end else if (tcnt_q > START_MAX_TK) begin
                  st_q <= RX_IDLE;
               end
            end
            RX_WAIT: begin
               if (fall) begin
                  st_q <= RX_BIT;
                  if (bitcnt_q == ACK_BIT && ack_ok_q &&
                     !ctrl_q[SUPPRESS_BIT] && en != 3'h0) begin
                     oe_b_q <= 1'b0;
                  end
               end else if (tcnt_q >= TIMEOUT_TK) begin
                  st_q <= RX_IDLE;
               end
            end
            RX_BIT: begin
               if (sample_now) begin
                  st_q <= RX_WAIT;
                  if (bitcnt_q < EOM_BIT) begin
                     shift_q <= {shift_q[6:0], line_q};
                     bitcnt_q <= bitcnt_q + 4'h1;
                  end else if (bitcnt_q == EOM_BIT) begin
                     eom_q <= line_q;
                     bitcnt_q <= ACK_BIT;
                     if (nbytes_q != FRAME_BYTES) begin
                        nbytes_q <= nbytes_q + 5'h01;
                     end
                     if (nbytes_q == 5'h00) begin
                        hit_q <= head_ok;
                        slot_q <= free_slot;
                        slot_ok_q <= free_ok;
                        ack_ok_q <= head_ok;
                     end else begin
                        ack_ok_q <= hit_q & slot_ok_q &
                           (nbytes_q < FRAME_BYTES);
                     end
                  end else if (eom_q) begin
                     st_q <= RX_IDLE;
                     commit_q <= hit_q & slot_ok_q &
                        (nbytes_q >= MIN_STORE_LEN);
                  end else begin
                     bitcnt_q <= 4'h0;
                  end
               end
            end
            default: begin
               st_q <= RX_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cec_out <= 1'b0;
      end else begin
         cec_out <= 1'b0;
      end
   end

   assign av_readdata = rdata_q;
   assign av_waitrequest = wait_q;
   assign cec_oe_b = oe_b_q;
   assign tx_start_pulse = start_q;
   assign interrupt_out_a = int_a_q;
   assign interrupt_out_b = int_b_q;
endmodule : cecrx_follower
`default_nettype wire

// [test/cecrx_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module cecrx_checker
   import cecrx_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire cecrx_req_t av_req,
   input wire logic [31:0] av_readdata,
   input wire logic av_waitrequest,
   input wire logic cec_in,
   input wire logic cec_out,
   input wire logic cec_oe_b,
   input wire logic tx_low_drive_error,
   input wire logic tx_start_pulse,
   input wire logic interrupt_out_a,
   input wire logic interrupt_out_b
);
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!rst_b);
   wire [7:0] idx = av_req.address[9:2];
   wire wr_ok = av_req.write && !av_waitrequest && av_req.byteenable[0];
   wire rd_ok = av_req.read && !av_waitrequest;
   wire start_c = wr_ok && idx == IDX_TX_START && av_req.writedata[0];
   wire [2:0] rdy_w = av_req.writedata[RDY_MSB:RDY_LSB];
   logic suppress_q;
   logic [2:0] en_q;
   logic [2:0] mask_a_q;
   logic [2:0] mask_b_q;
   logic [3:0] err_q;
   // Shadows of the host settings and of the low-drive count.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         suppress_q <= 1'b0;
         en_q <= 3'h0;
         mask_a_q <= 3'h0;
         mask_b_q <= 3'h0;
         err_q <= 4'h0;
      end else begin
         if (wr_ok && idx == IDX_CTRL) begin
            suppress_q <= av_req.writedata[SUPPRESS_BIT];
            en_q <= av_req.writedata[EN_MSB:EN_LSB];
         end
         if (wr_ok && idx == IDX_MASK_A) mask_a_q <= rdy_w;
         if (wr_ok && idx == IDX_MASK_B) mask_b_q <= rdy_w;
         if (start_c) err_q <= 4'h0;
         else if (tx_low_drive_error && err_q != LD_MAX) err_q <= err_q + 4'h1;
      end
   end
   sequence s_start;
      start_c;
   endsequence
   sequence s_pulse;
      tx_start_pulse ##1 !tx_start_pulse;
   endsequence
   a_wait_answer: assert property ((av_req.read || av_req.write)
      && av_waitrequest |=> !av_waitrequest) else $error("no bus answer");
   a_wait_single: assert property (!av_waitrequest |=> av_waitrequest)
      else $error("bus answer longer than one cycle");
   a_wait_idle: assert property (!(av_req.read || av_req.write)
      |=> av_waitrequest) else $error("bus answer without request");
   a_start_pulse: assert property (s_start |=> s_pulse)
      else $error("start pulse missing");
   a_pulse_cause: assert property ($rose(tx_start_pulse) |-> $past(start_c))
      else $error("start pulse without start write");
   a_err_read: assert property (rd_ok && idx == IDX_TX_ERR
      |-> av_readdata == {24'h0, $past(err_q), 4'h0})
      else $error("error count");
   a_no_ack_suppr: assert property ($fell(cec_oe_b)
      |-> !$past(suppress_q)) else $error("acknowledge while suppressed");
   a_ack_enabled: assert property ($fell(cec_oe_b)
      |-> $past(en_q) != 3'h0)
      else $error("acknowledge with no address enabled");
   a_irq_a_mask: assert property ((mask_a_q == 3'h0) [*2]
      |-> !interrupt_out_a) else $error("interrupt a while masked");
   a_irq_b_mask: assert property ((mask_b_q == 3'h0) [*2]
      |-> !interrupt_out_b) else $error("interrupt b while masked");
endmodule : cecrx_checker
bind cecrx_follower cecrx_checker i_cecrx_checker (.clk(clk), .rst_b(rst_b),
   .av_req(av_req), .av_readdata(av_readdata),
   .av_waitrequest(av_waitrequest), .cec_in(cec_in), .cec_out(cec_out),
   .cec_oe_b(cec_oe_b), .tx_low_drive_error(tx_low_drive_error),
   .tx_start_pulse(tx_start_pulse), .interrupt_out_a(interrupt_out_a),
   .interrupt_out_b(interrupt_out_b));
`default_nettype wire

// [test/cecrx_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module cecrx_partner
   import cecrx_pkg::*;
(
   input wire logic clk,
   input wire logic line,
   output logic drive,
   output logic blk_done,
   output logic blk_ack
);
   initial begin
      drive = 1'b1;
      blk_done = 1'b0;
      blk_ack = 1'b0;
   end
   // Sends a header and one data block; the line is released outside frames.
   task automatic send(input logic [7:0] h, input logic [7:0] d);
      logic [7:0] b;
      logic v;
      int lo;
      drive <= 1'b0;
      repeat (370 * TICK_CYC) @(posedge clk);
      drive <= 1'b1;
      repeat (40 * TICK_CYC) @(posedge clk);
      for (int n = 0; n < 20; n++) begin
         b = (n < 10) ? h : d;
         v = (n % 10 < 8) ? b[7 - n % 10] : (n % 10 == 8) ? (n >= 10) : 1'b1;
         lo = v ? 60 * TICK_CYC : 150 * TICK_CYC;
         for (int c = 0; c < 240 * TICK_CYC; c++) begin
            drive <= (c >= lo);
            blk_done <= (n % 10 == 9 && c == int'(SAMPLE_TK) * TICK_CYC);
            blk_ack <= !line;
            @(posedge clk);
         end
      end
      blk_done <= 1'b0;
      repeat (240 * TICK_CYC) @(posedge clk);
   endtask : send
endmodule : cecrx_partner
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import cecrx_pkg::*;
;
   logic clk;
   logic rst_b;
   cecrx_req_t req;
   logic [31:0] av_readdata;
   logic av_waitrequest;
   logic cec_out;
   logic cec_oe_b;
   logic err_pulse;
   logic drv;
   logic blk_done;
   logic blk_ack;
   logic irq_a;
   logic irq_b;
   logic tx_go;
   logic [31:0] rd_q[$];
   logic ack_q[$];
   int cmp_count;
   int fail_count;
   logic [31:0] rnd;
   logic [3:0] a0;
   logic [7:0] dat;
   wire line_w = drv & (cec_oe_b | cec_out);
   cecrx_follower i_cecrx_follower (.clk(clk), .rst_b(rst_b), .av_req(req),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
      .cec_in(line_w), .cec_out(cec_out), .cec_oe_b(cec_oe_b),
      .tx_low_drive_error(err_pulse), .tx_start_pulse(tx_go),
      .interrupt_out_a(irq_a), .interrupt_out_b(irq_b));
   cecrx_partner i_cecrx_partner (.clk(clk), .line(line_w), .drive(drv),
      .blk_done(blk_done), .blk_ack(blk_ack));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task cmp(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : cmp
   task cmp_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: bit %b, expected %b", $time, got, exp);
      end
   endtask : cmp_bit
   task complete_run;
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run
   task bus(input logic r, input logic [7:0] i, input logic [7:0] d);
      @(posedge clk);
      req <= '{r, !r, {i, 2'b00}, {24'h0, d}, 4'hF};
      do @(posedge clk); while (av_waitrequest !== 1'b0);
      req <= '0;
   endtask : bus
   task wr(input logic [7:0] i, input logic [7:0] d);
      bus(1'b0, i, d);
   endtask : wr
   task rd(input logic [7:0] i, input logic [7:0] e);
      rd_q.push_back({24'h0, e});
      bus(1'b1, i, 8'h00);
   endtask : rd
   task pulse(input int n);
      repeat (n) begin
         @(posedge clk);
         err_pulse <= 1'b1;
         @(posedge clk);
         err_pulse <= 1'b0;
      end
   endtask : pulse
   task frm(input logic [3:0] dst, input logic [7:0] d, input logic ah,
      input logic ad);
      ack_q.push_back(ah);
      ack_q.push_back(ad);
      i_cecrx_partner.send({4'h0, dst}, d);
   endtask : frm
   // Takes the oldest note whenever read data appears or a block's acknowledge bit is sampled.
   always @(posedge clk) begin
      if (req.read && av_waitrequest === 1'b0) begin
         cmp(av_readdata, rd_q.pop_front());
      end
      if (blk_done === 1'b1) cmp_bit(blk_ack, ack_q.pop_front());
   end
   // Eight frames of about 5500 cycles each plus register traffic fit inside.
   initial begin
      #4500000;
      fail_count++;
      complete_run;
   end
   initial begin
      req = '0;
      err_pulse = 1'b0;
      rst_b = 1'b0;
      cmp_count = 0;
      fail_count = 0;
      rnd = lfsr(32'h0F6B);
      a0 = rnd[3:0];
      dat = rnd[11:4];
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rd(IDX_CTRL, 8'h00);
      rd(IDX_ADDR_PAIR, 8'hFF);
      rd(IDX_ADDR_THIRD, 8'h0F);
      rd(IDX_STAMPS, 8'h00);
      rd(IDX_BUFSEL, 8'h00);
      rd(IDX_STATUS, 8'h00);
      rd(8'hC0, 8'h00);
      pulse(3);
      rd(IDX_TX_ERR, 8'h30);
      pulse(14);
      rd(IDX_TX_ERR, 8'hF0);
      wr(IDX_TX_START, 8'h01);
      @(posedge clk);
      cmp_bit(tx_go, 1'b1);
      rd(IDX_TX_ERR, 8'h00);
      wr(IDX_ADDR_PAIR, {a0 ^ 4'h1, a0});
      wr(IDX_ADDR_THIRD, {4'h0, a0 ^ 4'h2});
      wr(IDX_POWER, 8'h01);
      wr(IDX_MASK_A, 8'h38);
      wr(IDX_CTRL, 8'h12);
      frm(a0, dat, 1'b0, 1'b0);
      wr(IDX_CTRL, 8'h10);
      frm(a0 ^ 4'h1, dat, 1'b0, 1'b0);
      rd(IDX_STAMPS, 8'h00);
      frm(a0, dat, 1'b1, 1'b1);
      rd(IDX_STAMPS, 8'h01);
      rd(IDX_STATUS, 8'h08);
      rd(IDX_LEN0, 8'h02);
      rd(IDX_BUF0 + 8'h01, dat);
      cmp_bit(irq_a, 1'b1);
      frm(a0, dat, 1'b1, 1'b0);
      wr(IDX_CLEAR, 8'h02);
      repeat (4) @(posedge clk);
      rd(IDX_STAMPS, 8'h00);
      wr(IDX_BUFSEL, 8'h01);
      wr(IDX_CTRL, 8'h70);
      for (int i = 0; i < 3; i++) begin
         frm(a0 ^ 4'(i), dat + 8'(i), 1'b1, 1'b1);
      end
      rd(IDX_STAMPS, 8'h39);
      rd(IDX_STATUS, 8'h38);
      rd(IDX_BUF2 + 8'h01, dat + 8'h02);
      frm(a0, dat, 1'b1, 1'b0);
      wr(IDX_CLEAR, 8'h02);
      repeat (4) @(posedge clk);
      rd(IDX_STAMPS, 8'h24);
      wr(IDX_MASK_B, 8'h10);
      repeat (2) @(posedge clk);
      cmp_bit(irq_b, 1'b1);
      wr(IDX_MASK_A, 8'h00);
      rd(IDX_STATUS, 8'h10);
      cmp_bit(irq_a, 1'b0);
      complete_run;
   end
endmodule : tb_top
`default_nettype wire
